// [dshc_pkg.sv]
package dshc_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_LBA = 8'h04;
  localparam logic [7:0] OFS_SPARE = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0c;
  localparam logic [7:0] OFS_TMR1 = 8'h10;
  localparam logic [7:0] OFS_TMR2 = 8'h14;
  localparam logic [7:0] OFS_TMR3 = 8'h18;
  localparam logic [7:0] OFS_LOC = 8'h1c;
  localparam logic [7:0] OFS_RAM = 8'h80;
  // control bit positions
  localparam int CTL_START = 0;
  localparam int CTL_FMT = 1;
  localparam int CTL_CMPEN = 2;
  localparam int CTL_DIRRD = 3;
  // block to location split: sector 4 bits, head 1 bit, track 8 bits
  localparam int LBA_W = 13;
  localparam int LOC_SEC = 0;
  localparam int LOC_HEAD = 4;
  localparam int LOC_TRK = 5;
  // timer reload counts
  localparam logic [9:0] TMR1_RST = 10'd555;
  localparam logic [9:0] TMR2_RST = 10'd557;
  localparam logic [9:0] TMR3_RST = 10'd521;
  // ram layout
  localparam int RAM_AW = 5;
  localparam logic [4:0] HDR_FIRST = 5'h01;
  localparam logic [4:0] HDR_TRACK = 5'h02;
  // timing
  localparam int CLK_MHZ = 25;
  localparam int HEAD_SETTLE_US = 750;
  localparam int HEAD_SETTLE_CYC = HEAD_SETTLE_US * CLK_MHZ;
  localparam int VERIFY_HDRS = 3;
  localparam int REVS_TIMEOUT = 2;
  typedef enum logic [2:0] {SEQ0, SEQ1, SEQ3, SEQ5, SEQ6, SEQ7} dshc_seq_e;
  typedef enum logic [2:0] {SK_IDLE, SK_STEP, SK_SETTLE, SK_WSEC, SK_VER}
    dshc_seek_e;
endpackage

// [dshc_top.sv]
`timescale 1ns/1ps
// Overview of operation
// - block number split into head, track, sector; spare entry substituted.
// - header replica is held in a ram written before the check.
// - same track and head: positioning ends at once.
// - head change only: select head, settle 750 us, done.
// - track change: issue step pulses, then wait for a sector pulse.
// - sector pulse after positioning lets the header check begin.
// - replica bytes serialized against read data; mismatch aborts to wait.
// - check repeats per sector; two revolutions without done flags timeout.
// - after match, route disk to ram on read, ram to disk on write.
// - timer selected by bus write and strobe, loaded 555, 557, 521.
// - ram bytes 0 and 1 are zero, track at 2, byte 1 compared first.
// - start releases error flag, timer flags, clock selector, latches.
// - sector pulse moves the sequencer from sequence 0 to 1, or to 5 if format is set.
// - sequencer is a rom function whose latch feeds back its address.
// - on sync in sequence 0 go to 5 (write) if format is set, else 1.
// - sequence 1 waits for count end, then goes only to 3.
// - paths steered by address bit four, format, compare enable, direction.
// - in sequence 7 a byte strobe follows each completed byte at bit 1.
// - sequence 1 runs the divide by eight on crystal bit clock.
// - after a seek, three consecutive matching headers confirm position.
// - from sync wait, first high compare output enters sequence 7.
// - header done with bit four: sequence 6 on read, 5 on write.
module dshc_top
  import dshc_pkg::*;
#(
  parameter int SETTLE_CYC = dshc_pkg::HEAD_SETTLE_CYC,
  parameter int REV_CYC = 416667
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // analog board
  input wire logic sector_sync_mark,
  input wire logic nrz_read_stream,
  input wire logic rd_bit_tick,
  output logic read_gate,
  // head positioning
  output logic step_pulse,
  output logic step_dir,
  output logic head_sel,
  // data routing after match
  output logic sector_done,
  output logic serial_byte_strobe,
  output logic route_to_ram,
  output logic route_to_disk
);
  import dshc_pkg::*;

  function automatic dshc_seq_e seq_rom(input dshc_seq_e s,
    input logic sync, input logic fmt, input logic cend, input logic cmp,
    input logic cmpen, input logic a4, input logic dirrd, input logic miss);
    dshc_seq_e n;
    n = s;
    case (s)
      SEQ0: if (sync) n = fmt ? SEQ5 : SEQ1;
      SEQ1: if (cend) n = SEQ3;
      SEQ3: if (cmp && cmpen) n = SEQ7;
      SEQ7:
      begin
        if (a4) n = dirrd ? SEQ6 : SEQ5;
        else if (miss) n = SEQ0;
      end
      SEQ5, SEQ6: n = s;
      default: n = SEQ0;
    endcase
    return n;
  endfunction

  logic [3:0] ctrl_q;
  logic [LBA_W-1:0] spare_lba_q, spare_loc_q, loc_q, prev_q;
  logic prev_ok_q;
  logic [9:0] tld_q [3];
  logic [9:0] tcnt_q [3];
  logic [2:0] tout_q;
  logic [7:0] ram_q [32];
  logic wreq_q;
  logic [31:0] rdata_q;
  dshc_seq_e seq_q, seq_d;
  logic [2:0] bit_q;
  logic pend_q;
  logic [7:0] sh_q;
  logic [4:0] ra_q;
  logic clksel_q;
  logic err_q;
  logic rg_q, sd_q, ss_q, rr_q, rw_q;
  dshc_seek_e sk_q;
  logic [7:0] steps_q;
  logic [15:0] set_q;
  logic [1:0] ver_q;
  logic seek_ok_q, seek_busy_q, tmo_q;
  logic [19:0] rev_q;
  logic sp_q, sdir_q, hd_q;

  wire start = ctrl_q[CTL_START];
  wire req = avs_read || avs_write;
  wire acc = req && !wreq_q;
  wire do_wr = acc && avs_write;
  wire timer_select = do_wr && avs_address >= OFS_TMR1
    && avs_address <= OFS_TMR3;
  wire ram_hit = avs_address >= OFS_RAM;
  wire [4:0] ram_idx = avs_address[6:2];
  wire [LBA_W-1:0] lba_in = avs_writedata[LBA_W-1:0];
  wire [LBA_W-1:0] loc_new = (lba_in == spare_lba_q) ? spare_loc_q
    : lba_in;
  wire [7:0] trk_new = loc_new[LOC_TRK +: 8];
  wire [7:0] trk_old = prev_q[LOC_TRK +: 8];
  wire head_new = loc_new[LOC_HEAD];
  wire lba_wr = do_wr && avs_address == OFS_LBA;

  // bit clock: crystal until the read gate hands over to recovered clock
  wire tick = clksel_q ? rd_bit_tick : 1'b1;
  wire go = (seq_q == SEQ1) || (seq_q == SEQ7);
  wire byte_complete = tick && go && bit_q == 3'd7;
  wire strobe = tick && pend_q && go;
  wire count_end = (seq_q == SEQ1) && ra_q == HDR_FIRST;
  wire cmp_out = nrz_read_stream ^ ((seq_q == SEQ7) ? sh_q[7] : 1'b0);
  wire ram_addr_bit_four = ra_q[4];
  wire miss = tick && cmp_out;
  wire [4:0] ra_nx = ra_q + 5'd1;
  wire hdr_match = (seq_q == SEQ7) && tick && ram_addr_bit_four;

  always_comb
  begin
    seq_d = seq_q;
    if (!start)
      seq_d = SEQ0;
    else if (tick || seq_q == SEQ0)
      seq_d = seq_rom(seq_q, sector_sync_mark, ctrl_q[CTL_FMT], count_end,
        cmp_out, ctrl_q[CTL_CMPEN], ram_addr_bit_four, ctrl_q[CTL_DIRRD],
        miss);
  end

  // rom address latch
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      seq_q <= SEQ0;
    else
      seq_q <= seq_d;
  end

  // divide by eight, byte strobe and ram address counter
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bit_q <= 3'd0;
      pend_q <= 1'b0;
      ra_q <= 5'd0;
    end
    else if (!start || seq_q == SEQ0)
    begin
      bit_q <= 3'd0;
      pend_q <= 1'b0;
      ra_q <= 5'd0;
    end
    else
    begin
      if (seq_q == SEQ3)
        bit_q <= 3'd0;
      else if (tick && go)
        bit_q <= bit_q + 3'd1;
      if (byte_complete)
        pend_q <= 1'b1;
      else if (strobe)
        pend_q <= 1'b0;
      if (strobe && (seq_q == SEQ1 || ctrl_q[CTL_CMPEN]))
        ra_q <= ra_nx;
    end
  end

  // serializer holding the replica byte
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      sh_q <= 8'h00;
    else if (seq_q == SEQ3)
      sh_q <= ram_q[ra_q];
    else if (seq_q == SEQ7 && byte_complete)
      sh_q <= ram_q[ra_nx];
    else if (seq_q == SEQ7 && tick)
      sh_q <= {sh_q[6:0], 1'b0};
  end

  // clock selector, error flag and sequencer outputs
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      clksel_q <= 1'b0;
      err_q <= 1'b0;
      rg_q <= 1'b0;
      sd_q <= 1'b0;
      ss_q <= 1'b0;
      rr_q <= 1'b0;
      rw_q <= 1'b0;
    end
    else
    begin
      clksel_q <= start && (seq_d == SEQ3 || seq_d == SEQ7
        || seq_d == SEQ5 || seq_d == SEQ6);
      err_q <= start && (err_q || (seq_q == SEQ7 && miss
        && !ram_addr_bit_four));
      rg_q <= start && seq_d != SEQ0 && seq_d != SEQ1;
      sd_q <= hdr_match;
      ss_q <= strobe;
      rr_q <= seq_d == SEQ6;
      rw_q <= seq_d == SEQ5;
    end
  end

  // counter timer: decrements once per byte, flags at zero
  for (genvar i = 0; i < 3; i++)
  begin : g_tmr
    always_ff @(posedge clk or negedge rstn)
    begin
      if (!rstn)
      begin
        tcnt_q[i] <= 10'd0;
        tout_q[i] <= 1'b0;
      end
      else if (timer_select && ram_idx[1:0] == 2'(i))
      begin
        tcnt_q[i] <= avs_writedata[9:0];
        tout_q[i] <= 1'b0;
      end
      else if (!start)
        tout_q[i] <= 1'b0;
      else if (byte_complete && tcnt_q[i] != 10'd0)
      begin
        tcnt_q[i] <= tcnt_q[i] - 10'd1;
        tout_q[i] <= tcnt_q[i] == 10'd1;
      end
    end
  end

  // header replica ram; bytes 0 and 1 stay zero
  for (genvar j = 0; j < 32; j++)
  begin : g_ram
    always_ff @(posedge clk or negedge rstn)
    begin
      if (!rstn)
        ram_q[j] <= 8'h00;
      else if (j > 1 && do_wr && ram_hit && ram_idx == 5'(j))
        ram_q[j] <= avs_writedata[7:0];
    end
  end

  // positioning engine
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sk_q <= SK_IDLE;
      loc_q <= '0;
      prev_q <= '0;
      prev_ok_q <= 1'b0;
      steps_q <= 8'h00;
      set_q <= 16'h0000;
      sp_q <= 1'b0;
      sdir_q <= 1'b0;
      hd_q <= 1'b0;
      ver_q <= 2'd0;
      seek_ok_q <= 1'b0;
    end
    else
    begin
      sp_q <= 1'b0;
      case (sk_q)
        SK_IDLE:
          if (lba_wr)
          begin
            loc_q <= loc_new;
            prev_q <= loc_new;
            prev_ok_q <= 1'b1;
            hd_q <= head_new;
            if (prev_ok_q && trk_new == trk_old
                && head_new == prev_q[LOC_HEAD])
              sk_q <= SK_IDLE;
            else if (prev_ok_q && trk_new == trk_old)
            begin
              set_q <= 16'(SETTLE_CYC - 1);
              sk_q <= SK_SETTLE;
            end
            else
            begin
              sdir_q <= trk_new > trk_old;
              steps_q <= (trk_new > trk_old) ? trk_new - trk_old
                : trk_old - trk_new;
              seek_ok_q <= 1'b0;
              sk_q <= SK_STEP;
            end
          end
        SK_SETTLE:
          if (set_q == 16'h0000)
            sk_q <= SK_IDLE;
          else
            set_q <= set_q - 16'h0001;
        SK_STEP:
          if (steps_q == 8'h00)
            sk_q <= SK_WSEC;
          else if (!sp_q)
          begin
            sp_q <= 1'b1;
            steps_q <= steps_q - 8'h01;
          end
        SK_WSEC:
          if (sector_sync_mark)
          begin
            ver_q <= 2'd0;
            sk_q <= SK_VER;
          end
        SK_VER:
          if (seq_q == SEQ7 && miss && !ram_addr_bit_four)
            ver_q <= 2'd0;
          else if (hdr_match)
          begin
            if (ver_q == 2'(VERIFY_HDRS - 1))
            begin
              seek_ok_q <= 1'b1;
              sk_q <= SK_IDLE;
            end
            else
              ver_q <= ver_q + 2'd1;
          end
        default: sk_q <= SK_IDLE;
      endcase
    end
  end

  // two revolution watchdog on sector done; set wins over clear
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rev_q <= 20'd0;
      tmo_q <= 1'b0;
    end
    else if (!start || sd_q)
      rev_q <= 20'd0;
    else if (rev_q == 20'(REVS_TIMEOUT * REV_CYC - 1))
    begin
      tmo_q <= 1'b1;
      rev_q <= 20'd0;
    end
    else
    begin
      rev_q <= rev_q + 20'd1;
      if (lba_wr)
        tmo_q <= 1'b0;
    end
  end

  // control and spare registers
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_q <= 4'h4;
      spare_lba_q <= '1;
      spare_loc_q <= '0;
    end
    else if (do_wr && avs_address == OFS_CTRL)
      ctrl_q <= avs_writedata[3:0];
    else if (do_wr && avs_address == OFS_SPARE)
    begin
      spare_lba_q <= avs_writedata[LBA_W-1:0];
      spare_loc_q <= avs_writedata[16 +: LBA_W];
    end
  end

  wire [31:0] stat_w = {16'h0000, tmo_q, seek_ok_q, sk_q != SK_IDLE,
    err_q, tout_q, clksel_q, 1'b0, ra_q[2:0], 1'b0, seq_q};
  wire [31:0] rd_mux = ram_hit ? {24'h0, ram_q[ram_idx]}
    : avs_address == OFS_CTRL ? {28'h0, ctrl_q}
    : avs_address == OFS_SPARE ? {3'h0, spare_loc_q, 3'h0, spare_lba_q}
    : avs_address == OFS_STAT ? stat_w
    : avs_address == OFS_TMR1 ? {22'h0, tcnt_q[0]}
    : avs_address == OFS_TMR2 ? {22'h0, tcnt_q[1]}
    : avs_address == OFS_TMR3 ? {22'h0, tcnt_q[2]}
    : avs_address == OFS_LOC ? {19'h0, loc_q}
    : 32'h0000_0000;

  // one wait state per access so read data come from a flop
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wreq_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      wreq_q <= !(req && wreq_q);
      if (req && wreq_q)
        rdata_q <= rd_mux;
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wreq_q;
  assign read_gate = rg_q;
  assign step_pulse = sp_q;
  assign step_dir = sdir_q;
  assign head_sel = hd_q;
  assign sector_done = sd_q;
  assign serial_byte_strobe = ss_q;
  assign route_to_ram = rr_q;
  assign route_to_disk = rw_q;

  hold_seq0_a: assert property (@(posedge clk) disable iff (!rstn)
    !start |=> seq_q == SEQ0) else $error("seq not held");
  sync_move_a: assert property (@(posedge clk) disable iff (!rstn)
    start && seq_q == SEQ0 && sector_sync_mark |=>
    seq_q == (ctrl_q[CTL_FMT] ? SEQ5 : SEQ1)) else $error("sync path");
  seq1_exit_a: assert property (@(posedge clk) disable iff (!rstn)
    seq_q == SEQ1 && start |=> seq_q inside {SEQ1, SEQ3})
    else $error("seq1 exit");
  cmp_enter_a: assert property (@(posedge clk) disable iff (!rstn)
    start && seq_q == SEQ3 && tick && nrz_read_stream && ctrl_q[CTL_CMPEN]
    |=> seq_q == SEQ7) else $error("no seq7");
  hdr_exit_a: assert property (@(posedge clk) disable iff (!rstn)
    start && hdr_match |=> seq_q == (ctrl_q[CTL_DIRRD] ? SEQ6 : SEQ5)
    ##0 sector_done) else $error("exit path");
  miss_abort_a: assert property (@(posedge clk) disable iff (!rstn)
    start && seq_q == SEQ7 && miss && !ram_addr_bit_four |=> seq_q == SEQ0)
    else $error("no abort");
  byte_strb_a: assert property (@(posedge clk) disable iff (!rstn)
    seq_q == SEQ7 && byte_complete && start && seq_d == SEQ7 ##1
    (seq_q == SEQ7 && tick) |=> serial_byte_strobe)
    else $error("no strobe");
  xtal_clk_a: assert property (@(posedge clk) disable iff (!rstn)
    seq_q == SEQ1 |-> !clksel_q) else $error("clock sel");
  same_loc_a: assert property (@(posedge clk) disable iff (!rstn)
    sk_q == SK_IDLE && lba_wr && prev_ok_q && loc_new == prev_q
    |=> sk_q == SK_IDLE) else $error("needless seek");
  ram_zero_a: assert property (@(posedge clk) disable iff (!rstn)
    ram_q[0] == 8'h00 && ram_q[1] == 8'h00) else $error("ram0");
  tmr_load_a: assert property (@(posedge clk) disable iff (!rstn)
    timer_select && ram_idx[1:0] == 2'd0 |=>
    tcnt_q[0] == $past(avs_writedata[9:0])) else $error("tmr");
  wait_one_a: assert property (@(posedge clk) disable iff (!rstn)
    req && wreq_q |=> !avs_waitrequest) else $error("wait");
  c_match_c: cover property (@(posedge clk) disable iff (!rstn) hdr_match);
  c_abort_c: cover property (@(posedge clk) disable iff (!rstn)
    seq_q == SEQ7 && miss);
  c_seek_c: cover property (@(posedge clk) disable iff (!rstn)
    sk_q == SK_VER && seek_ok_q);
endmodule

// [dshc_top_end.sv]
`timescale 1ns/1ps

// [dshc_analog_model.sv]
`timescale 1ns/1ps
module dshc_analog_model
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // bench control
  input wire logic go,
  input wire logic [3:0] tick_gap,
  input wire logic [119:0] hdr_bits,
  input wire logic [7:0] flip_idx,
  // from the controller
  input wire logic read_gate,
  input wire logic step_pulse,
  input wire logic step_dir,
  // to the controller
  output logic sector_sync_mark,
  output logic nrz_read_stream,
  output logic rd_bit_tick,
  output logic [7:0] track_q
);
  logic [7:0] bit_q;
  logic [3:0] gap_q;
  logic [7:0] pos;
  logic bit_val;
  // sixteen zero sync bits, one marker bit, then the image msb first
  assign pos = 8'd136 - bit_q;
  assign bit_val = (bit_q == 8'd16) ? 1'b1 :
    (bit_q > 8'd16 && bit_q < 8'd137) ?
    (hdr_bits[pos[6:0]] ^ ((bit_q - 8'd17) == flip_idx)) : 1'b0;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sector_sync_mark <= 1'b0;
      nrz_read_stream <= 1'b0;
      rd_bit_tick <= 1'b0;
      track_q <= 8'h00;
      bit_q <= 8'h00;
      gap_q <= 4'h0;
    end
    else
    begin
      sector_sync_mark <= go;
      // the line changes every cycle off a tick, so stale bits never pass
      rd_bit_tick <= 1'b0;
      nrz_read_stream <= ~nrz_read_stream;
      if (step_pulse)
        track_q <= step_dir ? track_q + 8'h01 : track_q - 8'h01;
      if (go)
      begin
        bit_q <= 8'h00;
        gap_q <= 4'h0;
      end
      else if (read_gate && gap_q >= tick_gap - 4'h1)
      begin
        gap_q <= 4'h0;
        rd_bit_tick <= 1'b1;
        nrz_read_stream <= bit_val;
        if (bit_q != 8'hff)
          bit_q <= bit_q + 8'h01;
      end
      else
        gap_q <= read_gate ? gap_q + 4'h1 : 4'h0;
    end
  end
endmodule

// [tb.sv]
`timescale 1ns/1ps
module tb;
  import dshc_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, sector_sync_mark, nrz_read_stream, rd_bit_tick;
  logic read_gate, step_pulse, step_dir, head_sel, sector_done;
  logic serial_byte_strobe, route_to_ram, route_to_disk;
  logic go = 1'b0;
  logic [3:0] gap = 4'h1;
  logic [119:0] hdr = '0;
  logic [7:0] flip = 8'hff;
  logic [7:0] track;
  logic done;
  int n_errors = 0;
  int checks = 0;
  int n_strobe = 0;

  always #20 clk = ~clk;
  always @(posedge clk)
    if (go)
      n_strobe <= 0;
    else if (serial_byte_strobe === 1'b1)
      n_strobe <= n_strobe + 1;

  dshc_top #(.SETTLE_CYC(20), .REV_CYC(200)) i_dshc_top (.clk, .rstn,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .sector_sync_mark, .nrz_read_stream, .rd_bit_tick,
    .read_gate, .step_pulse, .step_dir, .head_sel, .sector_done,
    .serial_byte_strobe, .route_to_ram, .route_to_disk);
  dshc_analog_model i_dshc_analog_model (.clk, .rstn, .go,
    .tick_gap(gap), .hdr_bits(hdr), .flip_idx(flip), .read_gate,
    .step_pulse, .step_dir, .sector_sync_mark, .nrz_read_stream,
    .rd_bit_tick, .track_q(track));

  task automatic report_and_stop();
    if (n_errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic av(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    int n;
    logic wr_wait;
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= d;
    n = 0;
    q = 32'h0;
    // look at the settled values ahead of the edge they are sampled at,
    // so the slave's own update at that edge cannot race the bench
    do
    begin
      @(negedge clk);
      wr_wait = avs_waitrequest;
      q = avs_readdata;
      @(posedge clk);
      n++;
    end
    while (wr_wait !== 1'b0 && n < 64);
    if (n >= 64)
      n_errors++;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    av(1'b1, a, d, q);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] e);
    logic [31:0] q;
    av(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask

  task automatic pulse_go(input logic [3:0] g);
    gap <= g;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask

  // one sector pass; ends on a match or when the read gate drops again
  task automatic frame(input logic [3:0] g, input logic [7:0] f);
    int n;
    logic seen;
    flip <= f;
    pulse_go(g);
    done = 1'b0;
    seen = 1'b0;
    n = 0;
    while (n < 3000 && !done && !(seen && read_gate === 1'b0))
    begin
      @(posedge clk);
      n++;
      seen = seen | (read_gate === 1'b1);
      done = (sector_done === 1'b1);
    end
    if (n >= 3000)
      n_errors++;
    repeat (3) @(posedge clk);
  endtask

  task automatic load_hdr(input logic [7:0] t, input logic h,
    input logic [3:0] s);
    logic [7:0] b;
    logic [119:0] img;
    img = '0;
    for (int i = 2; i < 16; i++)
    begin
      b = (i == 2) ? t : (i == 3) ? {7'h0, h} : (i == 4) ? {4'h0, s} :
        8'(8'h30 + i);
      wr(OFS_RAM + 8'(4 * i), {24'h0, b});
      img[127 - 8 * i -: 8] = b;
    end
    hdr <= img;
  endtask

  task automatic t_regs();
    rdc(OFS_CTRL, 32'hf, 32'h4);
    rdc(8'h40, 32'hffffffff, 32'h0);
    wr(OFS_RAM, 32'hff);
    wr(OFS_RAM + 8'h04, 32'hff);
    rdc(OFS_RAM, 32'hff, 32'h0);
    rdc(OFS_RAM + 8'h04, 32'hff, 32'h0);
    wr(OFS_TMR1, {22'h0, TMR1_RST});
    wr(OFS_TMR2, {22'h0, TMR2_RST});
    wr(OFS_TMR3, {22'h0, TMR3_RST});
    rdc(OFS_TMR1, 32'h3ff, 32'h22b);
    rdc(OFS_TMR2, 32'h3ff, 32'h22d);
    rdc(OFS_TMR3, 32'h3ff, 32'h209);
    pulse_go(4'h1);
    repeat (20) @(posedge clk);
    rdc(OFS_STAT, 32'h7, 32'h0);
    chk({31'h0, read_gate}, 32'h0);
  endtask

  task automatic t_seek();
    int n;
    load_hdr(8'h03, 1'b0, 4'h2);
    rdc(OFS_RAM + 8'h08, 32'hff, 32'h3);
    wr(OFS_LBA, 32'h62);
    n = 0;
    while (track !== 8'h03 && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    repeat (10) @(posedge clk);
    chk({24'h0, track}, 32'h3);
    rdc(OFS_STAT, 32'h6000, 32'h2000);
    wr(OFS_CTRL, 32'hd);
    frame(4'h3, 8'hff);
    chk({31'h0, done}, 32'h1);
    chk(n_strobe, 32'h10);
    chk({31'h0, route_to_ram}, 32'h1);
    rdc(OFS_STAT, 32'h7, 32'h4);
    for (int i = 0; i < 2; i++)
    begin
      wr(OFS_CTRL, 32'h4);
      wr(OFS_CTRL, 32'hd);
      frame(4'h1, 8'hff);
      chk({31'h0, done}, 32'h1);
    end
    rdc(OFS_STAT, 32'h6000, 32'h4000);
  endtask

  task automatic t_head();
    wr(OFS_LBA, 32'h72);
    rdc(OFS_STAT, 32'h2000, 32'h2000);
    chk({31'h0, head_sel}, 32'h1);
    repeat (30) @(posedge clk);
    rdc(OFS_STAT, 32'h2000, 32'h0);
    chk({24'h0, track}, 32'h3);
    wr(OFS_SPARE, 32'h00730074);
    wr(OFS_LBA, 32'h74);
    rdc(OFS_LOC, 32'h1fff, 32'h73);
    rdc(OFS_STAT, 32'h2000, 32'h0);
    chk({24'h0, track}, 32'h3);
  endtask

  task automatic t_path();
    wr(OFS_CTRL, 32'h4);
    wr(OFS_CTRL, 32'hd);
    pulse_go(4'hf);
    repeat (30) @(posedge clk);
    rdc(OFS_STAT, 32'h7, 32'h2);
    chk({31'h0, read_gate}, 32'h1);
    wr(OFS_CTRL, 32'h4);
    wr(OFS_CTRL, 32'hd);
    frame(4'h2, 8'd40);
    chk({31'h0, done}, 32'h0);
    rdc(OFS_STAT, 32'h1007, 32'h1000);
    chk({31'h0, route_to_ram}, 32'h0);
  endtask

  task automatic t_write();
    wr(OFS_CTRL, 32'h4);
    wr(OFS_TMR1, 32'h2);
    wr(OFS_CTRL, 32'h5);
    frame(4'h1, 8'hff);
    chk({31'h0, done}, 32'h1);
    chk({30'h0, route_to_disk, route_to_ram}, 32'h2);
    rdc(OFS_STAT, 32'h207, 32'h203);
    repeat (300) @(posedge clk);
    rdc(OFS_STAT, 32'h8000, 32'h0);
    repeat (150) @(posedge clk);
    rdc(OFS_STAT, 32'h8000, 32'h8000);
    wr(OFS_CTRL, 32'h4);
    rdc(OFS_STAT, 32'he07, 32'h0);
    chk({31'h0, route_to_disk}, 32'h0);
    wr(OFS_CTRL, 32'h7);
    pulse_go(4'h1);
    repeat (5) @(posedge clk);
    rdc(OFS_STAT, 32'h7, 32'h3);
    wr(OFS_CTRL, 32'h4);
  endtask

  initial
  begin
    repeat (40000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end

  initial
  begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_regs();
    t_seek();
    t_head();
    t_path();
    t_write();
    report_and_stop();
  end
endmodule
